// ===== src/igf_pkg.sv
// Purpose: constants and types for the intermittent ground fault block
// Assumes: 10 MHz hclk, one protection tick shared by all timers
// Notes: threshold register holds the squared r.m.s. pickup value
package igf_pkg;
  // ----------------------------------------------------------------
  // clock and tick
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TMR_W = 16;
  localparam int MSQ_LOG2 = 5;
  localparam int SMP_W = 16;
  localparam int SUM_W = 18;
  localparam int MSQ_W = 36;
  // ----------------------------------------------------------------
  // bus encodings and register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_EXT = 8'h08;
  localparam logic [7:0] OFS_TSUM = 8'h0c;
  localparam logic [7:0] OFS_TRES = 8'h10;
  localparam logic [7:0] OFS_NOS = 8'h14;
  localparam logic [7:0] OFS_MINTRIP = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_INTEG = 8'h20;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_SRST_BIT = 3;
  localparam logic [31:0] THRESH_RST = 32'h0001_0000;
  localparam logic [TMR_W-1:0] EXT_RST = 16'h0000;
  localparam logic [TMR_W-1:0] TSUM_RST = 16'h0014;
  localparam logic [TMR_W-1:0] TRES_RST = 16'h012c;
  localparam logic [7:0] NOS_RST = 8'h03;
  localparam logic [TMR_W-1:0] MINTRIP_RST = 16'h0096;
  typedef enum logic [1:0] {SRC_GND, SRC_SENS, SRC_SUM} igf_src_e;
  typedef enum {S_IDLE, S_ACTIVE, S_TRIP} igf_state_e;
endpackage

// ===== src/igf_msq.sv
// Purpose: block mean-square of a current sample stream
// Assumes: samples signed, at most one per cycle
// Notes: dc and every harmonic below half the sample rate are kept
`timescale 1ns/1ps
module igf_msq
  import igf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic smp_vld,
  input wire logic signed [SUM_W-1:0] smp,
  output logic msq_vld,
  output logic [MSQ_W-1:0] msq
);
  // ----------------------------------------------------------------
  // accumulate squares over 2^MSQ_LOG2 samples
  // ----------------------------------------------------------------
  logic [MSQ_W+MSQ_LOG2-1:0] acc_ff, nxt_acc;
  logic [MSQ_LOG2-1:0] cnt_ff, nxt_cnt;
  logic vld_ff, nxt_vld;
  logic [MSQ_W-1:0] msq_ff, nxt_msq;
  logic [MSQ_W-1:0] sq;
  logic [MSQ_W+MSQ_LOG2-1:0] sum;

  always_comb begin
    // square at full width: a product at operand width would wrap
    sq = $unsigned(MSQ_W'(smp) * MSQ_W'(smp));
    sum = acc_ff + {{MSQ_LOG2{1'b0}}, sq};
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_vld = 1'b0;
    nxt_msq = msq_ff;
    if (smp_vld) begin
      nxt_cnt = cnt_ff + 1'b1;
      if (&cnt_ff) begin
        // mean is a shift, so the window length stays a power of two
        nxt_msq = sum[MSQ_W+MSQ_LOG2-1:MSQ_LOG2];
        nxt_vld = 1'b1;
        nxt_acc = '0;
      end else begin
        nxt_acc = sum;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= '0;
      cnt_ff <= '0;
      vld_ff <= 1'b0;
      msq_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      vld_ff <= nxt_vld;
      msq_ff <= nxt_msq;
    end
  end

  assign msq_vld = vld_ff;
  assign msq = msq_ff;
endmodule

// ===== src/igf_top.sv
// Purpose: intermittent ground fault detection, integration and trip
// Assumes: AHB-Lite slave, zero wait states, samples synchronous to hclk
// Notes: all timers count protection ticks of TICK_CYCLES clocks
//
// Notes on behaviour
// [R1] compare r.m.s. (dc and harmonics kept) of selected current with threshold
// [R2] current source is ground, sensitive ground, or summed phase currents
// [R3] raise raw fault detected while r.m.s. exceeds threshold
// [R4] count raw pickups; flag intermittent fault when count reaches setting
// [R5] stabilized pickup stretches raw detection by extension time
// [R6] integrate stabilized pickup time; flag summation expired at threshold
// [R7] after summation expiry trip only while fault is present
// [R8] hold trip at least the minimum trip duration
// [R9] trip end clears counter, integrator, timers; back to normal
// [R10] fault starts reset timer with integrator; show reset timer running
// [R11] each new fault reloads reset timer; integrator is not reloaded
// [R12] reset timer expiry without fault clears all; later fault is new event
// [R13] log raw detection only until intermittent flag is set
// [R14] duplicate raw detection for leds and relays, never suppressed
// [R15] no reclosing start from this function
// [R16] no breaker failure start from this function
// [R17] integrator holds value on dropout and resumes from it
// [R18] off setting stops pickup, counting and trip
// [R19] fault event closes on reset timer expiry or trip end
// [R20] common tick drives timers; soft reset clears event state; code keeps raw detection and settings
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module igf_top
  import igf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic samp_vld,
  input wire logic signed [SMP_W-1:0] samp_gnd,
  input wire logic signed [SMP_W-1:0] samp_sens,
  input wire logic signed [SMP_W-1:0] samp_pa,
  input wire logic signed [SMP_W-1:0] samp_pb,
  input wire logic signed [SMP_W-1:0] samp_pc,
  output logic raw_fault_detected,
  output logic intermittent_fault_flag,
  output logic stabilized_pickup,
  output logic summation_expired_msg,
  output logic fault_trip_output,
  output logic clear_timer_running_msg,
  output logic fault_log_msg,
  output logic fault_relay_msg,
  output logic event_closed,
  output logic reclose_start,
  output logic bkr_fail_start
);
  // ----------------------------------------------------------------
  // bus slave and settings
  // ----------------------------------------------------------------
  logic wr_ff, nxt_wr;
  logic [7:0] wa_ff, nxt_wa;
  logic [31:0] rd_ff, nxt_rd, rmux;
  logic on_ff, nxt_on, srst_ff, nxt_srst;
  logic [1:0] src_ff, nxt_src;
  logic [31:0] thr_ff, nxt_thr;
  logic [TMR_W-1:0] ext_set_ff, nxt_ext_set, tsum_ff, nxt_tsum;
  logic [TMR_W-1:0] tres_set_ff, nxt_tres_set, mt_set_ff, nxt_mt_set;
  logic [7:0] nos_ff, nxt_nos;
  logic raw_ff, int_ff, stab_ff, sumexp_ff, trip_ff, trun_ff;
  logic log_ff, relay_ff, close_ff;
  logic [7:0] cnt_ff;
  logic [TMR_W-1:0] integ_ff;
  igf_state_e state_ff;
  logic take;

  always_comb begin
    take = hsel & hready & htrans[1];
    rmux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: rmux = {28'h0, 1'b0, src_ff, on_ff};
      OFS_THRESH: rmux = thr_ff;
      OFS_EXT: rmux = {16'h0, ext_set_ff};
      OFS_TSUM: rmux = {16'h0, tsum_ff};
      OFS_TRES: rmux = {16'h0, tres_set_ff};
      OFS_NOS: rmux = {24'h0, nos_ff};
      OFS_MINTRIP: rmux = {16'h0, mt_set_ff};
      OFS_STATUS: rmux = {24'h0, trun_ff, trip_ff, sumexp_ff, stab_ff, int_ff, raw_ff,
                          log_ff, relay_ff};
      OFS_INTEG: rmux = {16'h0, integ_ff};
      default: rmux = 32'h0000_0000;
    endcase
    nxt_rd = (take & ~hwrite) ? rmux : 32'h0000_0000;
    nxt_wr = take & hwrite & (hsize == HSIZE_WORD);
    nxt_wa = haddr[7:0];
    nxt_on = on_ff;
    nxt_src = src_ff;
    nxt_srst = 1'b0;
    nxt_thr = thr_ff;
    nxt_ext_set = ext_set_ff;
    nxt_tsum = tsum_ff;
    nxt_tres_set = tres_set_ff;
    nxt_nos = nos_ff;
    nxt_mt_set = mt_set_ff;
    if (wr_ff) begin
      case (wa_ff)
        OFS_CTRL: begin
          nxt_on = hwdata[CTRL_ON_BIT]; // [R18]
          nxt_src = hwdata[CTRL_SRC_LSB+1:CTRL_SRC_LSB];
          nxt_srst = hwdata[CTRL_SRST_BIT]; // [R20]
        end
        OFS_THRESH: nxt_thr = hwdata;
        OFS_EXT: nxt_ext_set = hwdata[TMR_W-1:0];
        OFS_TSUM: nxt_tsum = hwdata[TMR_W-1:0];
        OFS_TRES: nxt_tres_set = hwdata[TMR_W-1:0];
        OFS_NOS: nxt_nos = hwdata[7:0];
        OFS_MINTRIP: nxt_mt_set = hwdata[TMR_W-1:0];
        default: nxt_on = on_ff;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
      rd_ff <= 32'h0000_0000;
      on_ff <= 1'b0;
      src_ff <= 2'h0;
      srst_ff <= 1'b0;
      thr_ff <= THRESH_RST;
      ext_set_ff <= EXT_RST;
      tsum_ff <= TSUM_RST;
      tres_set_ff <= TRES_RST;
      nos_ff <= NOS_RST;
      mt_set_ff <= MINTRIP_RST;
    end else begin
      wr_ff <= nxt_wr;
      wa_ff <= nxt_wa;
      rd_ff <= nxt_rd;
      on_ff <= nxt_on;
      src_ff <= nxt_src;
      srst_ff <= nxt_srst;
      thr_ff <= nxt_thr;
      ext_set_ff <= nxt_ext_set;
      tsum_ff <= nxt_tsum;
      tres_set_ff <= nxt_tres_set;
      nos_ff <= nxt_nos;
      mt_set_ff <= nxt_mt_set;
    end
  end

  // ----------------------------------------------------------------
  // source select, mean square and tick
  // ----------------------------------------------------------------
  logic signed [SUM_W-1:0] smp_sel;
  logic msq_vld;
  logic [MSQ_W-1:0] msq;
  logic [13:0] tk_ff, nxt_tk;
  logic tick;

  always_comb begin
    case (src_ff)
      SRC_SENS: smp_sel = SUM_W'(samp_sens); // [R2]
      SRC_SUM: smp_sel = SUM_W'(samp_pa) + SUM_W'(samp_pb) + SUM_W'(samp_pc); // [R2]
      default: smp_sel = SUM_W'(samp_gnd); // [R2]
    endcase
    tick = (tk_ff == 14'(TICK_CYCLES - 1)); // [R20]
    nxt_tk = tick ? 14'h0000 : tk_ff + 14'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tk_ff <= 14'h0000;
    end else begin
      tk_ff <= nxt_tk;
    end
  end

  igf_msq u_msq (
    .hclk(hclk),
    .hresetn(hresetn),
    .smp_vld(samp_vld),
    .smp(smp_sel),
    .msq_vld(msq_vld),
    .msq(msq)
  );

  // ----------------------------------------------------------------
  // detection, integration and trip
  // ----------------------------------------------------------------
  logic nxt_raw, nxt_int, nxt_stab, nxt_sumexp, nxt_log, nxt_close;
  logic [7:0] nxt_cnt;
  logic [TMR_W-1:0] ext_ff, nxt_ext, nxt_integ, tres_ff, nxt_tres, mt_ff, nxt_mt;
  igf_state_e nxt_state;
  logic rise, expire, trip_end, clr;

  always_comb begin
    expire = (state_ff == S_ACTIVE) & tick & (tres_ff <= 16'h0001) & ~raw_ff;
    trip_end = (state_ff == S_TRIP) & (mt_ff == 16'h0000) & ~raw_ff; // [R8]
    clr = ~on_ff | srst_ff | expire | trip_end; // [R9] [R12] [R18]
    nxt_raw = raw_ff;
    if (!on_ff) begin
      nxt_raw = 1'b0; // [R18]
    end else if (msq_vld) begin
      nxt_raw = (msq > {4'h0, thr_ff}); // [R1] [R3]
    end
    rise = nxt_raw & ~raw_ff;
    nxt_cnt = clr ? {7'h00, rise} : cnt_ff + {7'h00, rise & ~&cnt_ff}; // [R4]
    // a pickup landing on the clear cycle still counts as one and sets the flag when nos_ff is 1: set wins
    nxt_int = (~clr & int_ff) | ((nxt_cnt >= nos_ff) & (nos_ff != 8'h00)); // [R4]
    nxt_ext = ext_ff;
    if (clr) begin
      nxt_ext = 16'h0000;
    end else if (raw_ff) begin
      nxt_ext = ext_set_ff; // [R5]
    end else if (tick && ext_ff != 16'h0000) begin
      nxt_ext = ext_ff - 16'h0001; // [R5]
    end
    nxt_stab = nxt_raw | (nxt_ext != 16'h0000); // [R5]
    nxt_integ = integ_ff;
    if (clr) begin
      nxt_integ = 16'h0000;
    end else if (tick && stab_ff && integ_ff != 16'hffff) begin
      nxt_integ = integ_ff + 16'h0001; // [R6] [R17]
    end
    nxt_state = state_ff;
    nxt_mt = 16'h0000;
    case (state_ff)
      S_IDLE: begin
        if (nxt_raw) begin
          nxt_state = S_ACTIVE; // [R10]
        end
      end
      S_ACTIVE: begin
        if (expire) begin
          nxt_state = S_IDLE; // [R12]
        end else if (sumexp_ff && raw_ff) begin
          nxt_state = S_TRIP; // [R7]
          nxt_mt = mt_set_ff; // [R8]
        end
      end
      S_TRIP: begin
        if (trip_end) begin
          nxt_state = S_IDLE; // [R9]
        end else if (tick && mt_ff != 16'h0000) begin
          nxt_mt = mt_ff - 16'h0001; // [R8]
        end else begin
          nxt_mt = mt_ff;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (!on_ff || srst_ff) begin
      nxt_state = S_IDLE; // [R18] [R20]
      nxt_mt = 16'h0000;
    end
    nxt_tres = tres_ff;
    if (clr) begin
      nxt_tres = 16'h0000;
    end else if (tick && tres_ff != 16'h0000) begin
      nxt_tres = tres_ff - 16'h0001;
    end
    if (nxt_raw && nxt_state != S_IDLE) begin
      nxt_tres = tres_set_ff; // [R10] [R11]
    end
    // summation is only meaningful inside an open fault event
    nxt_sumexp = ~clr & (nxt_state != S_IDLE) & (nxt_integ >= tsum_ff); // [R6]
    nxt_log = nxt_raw & ~nxt_int; // [R13]
    nxt_close = (state_ff != S_IDLE) & (expire | trip_end); // [R19]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_ff <= 1'b0;
      int_ff <= 1'b0;
      stab_ff <= 1'b0;
      sumexp_ff <= 1'b0;
      trip_ff <= 1'b0;
      trun_ff <= 1'b0;
      log_ff <= 1'b0;
      relay_ff <= 1'b0;
      close_ff <= 1'b0;
      cnt_ff <= 8'h00;
      ext_ff <= 16'h0000;
      integ_ff <= 16'h0000;
      tres_ff <= 16'h0000;
      mt_ff <= 16'h0000;
      state_ff <= S_IDLE;
    end else begin
      raw_ff <= nxt_raw;
      int_ff <= nxt_int;
      stab_ff <= nxt_stab;
      sumexp_ff <= nxt_sumexp;
      trip_ff <= (nxt_state == S_TRIP); // [R7]
      trun_ff <= (nxt_state != S_IDLE); // [R10]
      log_ff <= nxt_log;
      relay_ff <= nxt_raw; // [R14]
      close_ff <= nxt_close;
      cnt_ff <= nxt_cnt;
      ext_ff <= nxt_ext;
      integ_ff <= nxt_integ;
      tres_ff <= nxt_tres;
      mt_ff <= nxt_mt;
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // reclosing and breaker failure starts stay low: trip here is not
  // followed by a standing pickup, so those functions would misjudge it
  logic nostart_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nostart_ff <= 1'b0;
    end else begin
      nostart_ff <= 1'b0; // [R15] [R16]
    end
  end
  logic hro_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hro_ff <= 1'b0;
    end else begin
      hro_ff <= 1'b1;
    end
  end

  assign hreadyout = hro_ff;
  assign hresp = nostart_ff;
  assign hrdata = rd_ff;
  assign raw_fault_detected = raw_ff;
  assign intermittent_fault_flag = int_ff;
  assign stabilized_pickup = stab_ff;
  assign summation_expired_msg = sumexp_ff;
  assign fault_trip_output = trip_ff;
  assign clear_timer_running_msg = trun_ff;
  assign fault_log_msg = log_ff;
  assign fault_relay_msg = relay_ff;
  assign event_closed = close_ff;
  assign reclose_start = nostart_ff;
  assign bkr_fail_start = nostart_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_raw;
    (on_ff && msq_vld && msq > {4'h0, thr_ff}) |=> raw_ff;
  endproperty
  a_raw: assert property (p_raw) else $error("raw detect missed"); // [R3]
  property p_intf;
    $rose(int_ff) |-> (cnt_ff >= nos_ff);
  endproperty
  a_intf: assert property (p_intf) else $error("early intermittent flag"); // [R4]
  property p_stab;
    stab_ff == (raw_ff || ext_ff != 16'h0000);
  endproperty
  a_stab: assert property (p_stab) else $error("stabilized pickup wrong"); // [R5]
  property p_sum;
    sumexp_ff |-> (integ_ff >= tsum_ff && trun_ff);
  endproperty
  a_sum: assert property (p_sum) else $error("summation flag early"); // [R6]
  property p_trip;
    $rose(trip_ff) |-> ($past(raw_ff) && $past(sumexp_ff));
  endproperty
  a_trip: assert property (p_trip) else $error("trip without cause"); // [R7]
  property p_hold;
    $fell(trip_ff) && $past(on_ff) && !$past(srst_ff) |-> ($past(mt_ff) == 16'h0000);
  endproperty
  a_hold: assert property (p_hold) else $error("trip too short"); // [R8]
  property p_clr;
    $fell(trip_ff) |-> (cnt_ff <= {7'h00, raw_ff} && integ_ff == 16'h0000 && !trun_ff);
  endproperty
  a_clr: assert property (p_clr) else $error("state not cleared"); // [R9]
  property p_tres;
    (nxt_raw && on_ff && !srst_ff && !expire && !trip_end) |=>
      (trun_ff && tres_ff == $past(tres_set_ff));
  endproperty
  a_tres: assert property (p_tres) else $error("reset timer not loaded"); // [R11]
  property p_log;
    log_ff |-> (relay_ff && !int_ff);
  endproperty
  a_log: assert property (p_log) else $error("log not suppressed"); // [R13]
  property p_off;
    !on_ff |=> (!raw_ff && !trip_ff && cnt_ff == 8'h00);
  endproperty
  a_off: assert property (p_off) else $error("activity while off"); // [R18]
  property p_close;
    close_ff |-> (!trun_ff && integ_ff == 16'h0000 && !trip_ff);
  endproperty
  a_close: assert property (p_close) else $error("event closed dirty"); // [R19]

  c_trip: cover property ($rose(trip_ff));
  c_expire: cover property (close_ff && !$past(trip_ff));
  c_interm: cover property ($rose(int_ff));
endmodule

// ===== tb/igf_frontend.sv
// Purpose: current front end model, one sample per clock
// Assumes: fault puts a rippled current with dc on channel chan (2 = phases)
// Notes: healthy channels carry a small ripple, except samp_pc held at zero, and the phases sum to zero
`timescale 1ns/1ps
module igf_frontend
  import igf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fault,
  input wire logic [1:0] chan,
  output logic samp_vld,
  output logic signed [SMP_W-1:0] samp_gnd,
  output logic signed [SMP_W-1:0] samp_sens,
  output logic signed [SMP_W-1:0] samp_pa,
  output logic signed [SMP_W-1:0] samp_pb,
  output logic signed [SMP_W-1:0] samp_pc
);
  // ---------------------------------------------------------------
  // sample stream
  // ---------------------------------------------------------------
  logic ph;
  logic signed [SMP_W-1:0] big;
  logic signed [SMP_W-1:0] phs;
  logic signed [SMP_W-1:0] sml;
  // dc plus ripple: a fundamental-only measure would read this low
  assign big = ph ? 16'sh03e8 : 16'sh00c8;
  assign phs = ph ? 16'sh0190 : 16'sh0050;
  assign sml = ph ? 16'sh000a : -16'sh000a;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 1'b0;
      samp_vld <= 1'b0;
      samp_gnd <= 16'sh0000;
      samp_sens <= 16'sh0000;
      samp_pa <= 16'sh0000;
      samp_pb <= 16'sh0000;
      samp_pc <= 16'sh0000;
    end else begin
      ph <= ~ph;
      samp_vld <= 1'b1;
      samp_gnd <= (fault && chan == 2'h0) ? big : sml;
      samp_sens <= (fault && chan == 2'h1) ? big : sml;
      samp_pa <= (fault && chan == 2'h2) ? phs : sml;
      samp_pb <= (fault && chan == 2'h2) ? phs : -sml;
      samp_pc <= (fault && chan == 2'h2) ? phs : 16'sh0000;
    end
  end
endmodule

// ===== tb/test_igf_top.sv
// Purpose: self-checking bench for the intermittent ground fault block
// Assumes: short tick of 4 clocks, bus master per AHB-Lite single transfers
// Notes: every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
`define WAITC(c, b) begin wn = 0; while (!(c) && wn < (b)) begin @(posedge hclk); wn++; end \
  if (!(c)) begin mismatches++; $display("unexpected wait: expected %h seen %h", 1'b1, 1'b0); \
  print_verdict(); end end
module test_igf_top;
  import igf_pkg::*;
  localparam int TK = 4;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, samp_vld, fault;
  logic [31:0] haddr, hwdata, hrdata, dmy;
  logic [1:0] htrans, chan;
  logic [2:0] hsize;
  logic signed [SMP_W-1:0] sg, ss, sa, sb, sc;
  logic raw, flag, stab, sumexp, trip, trun, logm, relay, closed, recl, bkf;
  int mismatches = 0;
  int tests_run = 0;
  int wn;
  igf_top #(.TICK_CYCLES(TK)) igf_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .samp_vld(samp_vld), .samp_gnd(sg), .samp_sens(ss), .samp_pa(sa), .samp_pb(sb),
    .samp_pc(sc), .raw_fault_detected(raw), .intermittent_fault_flag(flag),
    .stabilized_pickup(stab), .summation_expired_msg(sumexp), .fault_trip_output(trip),
    .clear_timer_running_msg(trun), .fault_log_msg(logm), .fault_relay_msg(relay),
    .event_closed(closed), .reclose_start(recl), .bkr_fail_start(bkf));
  igf_frontend igf_frontend_i (.hclk(hclk), .hresetn(hresetn), .fault(fault), .chan(chan),
    .samp_vld(samp_vld), .samp_gnd(sg), .samp_sens(ss), .samp_pa(sa), .samp_pb(sb),
    .samp_pc(sc));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // entered just after a rising edge; leaves just after the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a}; hsize <= HSIZE_WORD;
    @(posedge hclk);
    `WAITC(hreadyout === 1'b1, 50)
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge hclk);
    `WAITC(hreadyout === 1'b1, 50)
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, dmy);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask
  // soft reset plus switch on, then timing settings in ticks
  task automatic cfg(input logic [1:0] s, input logic [15:0] ext, tsum, tres, mt);
    wr(OFS_CTRL, {28'h0000000, 1'b1, s, 1'b1});
    wr(OFS_EXT, {16'h0000, ext});
    wr(OFS_TSUM, {16'h0000, tsum});
    wr(OFS_TRES, {16'h0000, tres});
    wr(OFS_MINTRIP, {16'h0000, mt});
  endtask
  task automatic hold(input int c, output logic q);
    q = 1'b0;
    repeat (c) begin
      @(posedge hclk);
      q = q | raw | trip;
    end
  endtask
  task automatic pickup(output logic lg, output logic fl);
    fault <= 1'b1;
    `WAITC(raw === 1'b1, 100)
    lg = logm;
    `CHK("relay copy", 1'b1, relay)
    `CHK("reset timer running", 1'b1, trun)
    repeat (40) @(posedge hclk);
    fl = flag;
    fault <= 1'b0;
    `WAITC(raw === 1'b0, 100)
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] ofs [8] = '{OFS_THRESH, OFS_EXT, OFS_TSUM, OFS_TRES, OFS_NOS, OFS_MINTRIP,
                            OFS_STATUS, 8'h40};
    logic [31:0] rv [8] = '{THRESH_RST, {16'h0000, EXT_RST}, {16'h0000, TSUM_RST},
      {16'h0000, TRES_RST}, {24'h000000, NOS_RST}, {16'h0000, MINTRIP_RST}, 32'h0, 32'h0};
    logic [31:0] v;
    `CHK("idle outputs", 13'h0000, {raw, flag, stab, sumexp, trip, trun, logm, relay,
                                    closed, recl, bkf, hresp, 1'b0})
    foreach (ofs[i]) begin
      rd(ofs[i], v);
      `CHK("reset value", rv[i], v)
    end
    wr(OFS_INTEG, 32'h0000_ffff);
    rd(OFS_INTEG, v);
    `CHK("read-only integrator", 32'h0000_0000, v)
  endtask
  task automatic t_source();
    logic q, lg, fl;
    for (int s = 0; s < 3; s++) begin
      cfg(2'(s), 16'h0000, 16'hffff, 16'h012c, 16'h0096);
      chan <= 2'((s + 1) % 3);
      fault <= 1'b1;
      hold(120, q);
      `CHK("other source ignored", 1'b0, q)
      chan <= 2'(s);
      pickup(lg, fl);
    end
    wr(OFS_CTRL, 32'h0000_0000);
    chan <= 2'h0;
    fault <= 1'b1;
    hold(150, q);
    fault <= 1'b0;
    `CHK("function off", 1'b0, q)
  endtask
  task automatic t_count();
    logic lg, fl;
    cfg(2'h0, 16'h0000, 16'hffff, 16'h012c, 16'h0096);
    for (int i = 1; i <= 3; i++) begin
      pickup(lg, fl);
      `CHK("log copy", 1'(i < 3), lg)
      `CHK("intermittent flag", 1'(i == 3), fl)
    end
  endtask
  task automatic t_stretch();
    logic lg, fl;
    int n;
    cfg(2'h0, 16'h0008, 16'hffff, 16'h012c, 16'h0096);
    pickup(lg, fl);
    n = 0;
    while (stab === 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    `CHK("stretch length", 1'b1, n >= 6 * TK && n <= 10 * TK)
  endtask
  task automatic t_integ();
    logic lg, fl;
    logic [31:0] v1, v2, v3;
    cfg(2'h0, 16'h0000, 16'hffff, 16'h012c, 16'h0096);
    rd(OFS_INTEG, v1);
    `CHK("soft reset clears integrator", 32'h0, v1)
    pickup(lg, fl);
    rd(OFS_INTEG, v1);
    repeat (20) @(posedge hclk);
    rd(OFS_INTEG, v2);
    `CHK("integrator nonzero", 1'b1, v1 != 32'h0)
    `CHK("integrator held", v1, v2)
    pickup(lg, fl);
    rd(OFS_INTEG, v3);
    `CHK("integrator resumes", 1'b1, v3 > v1)
  endtask
  task automatic t_noflt();
    logic lg, fl, q;
    cfg(2'h0, 16'h0028, 16'h0028, 16'h012c, 16'h0096);
    pickup(lg, fl);
    hold(150, q);
    `CHK("expired while stretched", 1'b1, sumexp)
    `CHK("no trip without fault", 1'b0, q)
  endtask
  task automatic t_trip();
    logic [31:0] v;
    int n;
    cfg(2'h0, 16'h0000, 16'h0002, 16'h012c, 16'h0032);
    fault <= 1'b1;
    `WAITC(trip === 1'b1, 200)
    `CHK("trip needs expiry and fault", 2'b11, {sumexp, raw})
    `CHK("no reclose or breaker start", 2'b00, {recl, bkf})
    fault <= 1'b0;
    n = 0;
    while (trip === 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    `CHK("minimum trip time", 1'b1, n >= 49 * TK && n <= 52 * TK)
    `WAITC(closed === 1'b1, 3)
    rd(OFS_STATUS, v);
    `CHK("status after trip", 32'h0, v)
    rd(OFS_INTEG, v);
    `CHK("integrator after trip", 32'h0, v)
  endtask
  task automatic t_tres();
    logic [31:0] v;
    int n;
    cfg(2'h0, 16'h0000, 16'hffff, 16'h0005, 16'h0096);
    fault <= 1'b1;
    repeat (150) @(posedge hclk);
    `CHK("reset timer reloaded", 1'b1, trun)
    fault <= 1'b0;
    `WAITC(raw === 1'b0, 100)
    n = 0;
    while (trun === 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    `CHK("reset time", 1'b1, n >= 4 * TK && n <= 7 * TK)
    `WAITC(closed === 1'b1, 3)
    rd(OFS_INTEG, v);
    `CHK("integrator after expiry", 32'h0, v)
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; fault = 1'b0; chan = 2'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_source();
    t_count();
    t_stretch();
    t_integ();
    t_noflt();
    t_trip();
    t_tres();
    print_verdict();
  end
endmodule
